// ### hdl/rtt_defines.svh
// Notes on behaviour
// - Four independent timers, each reloads start value.
// - Sixteen-bit down counter, one step per tick.
// - Per-timer prescaler taps divide by 4/16/64/256.
// - One-shot stops at end; continuous reloads.
// - Four capture channels latch counter on event.
// - Four compares drive pins; two count events.
// - Four PWMs run independently or synchronised.
// - Any capture pin selectable as power trip.
`ifndef RTT_DEFINES_SVH
`define RTT_DEFINES_SVH

// ****************************************
// Sizes and field positions
// ****************************************
`define RTT_NUM_CH      4
`define RTT_CNT_W       16
`define RTT_PRE_W       8
`define RTT_NUM_EVT_CH  2

// ****************************************
// Prescaler tap masks (divide by 4, 16, 64, 256)
// ****************************************
`define RTT_TAP_DIV4    8'h03
`define RTT_TAP_DIV16   8'h0F
`define RTT_TAP_DIV64   8'h3F
`define RTT_TAP_DIV256  8'hFF

// ****************************************
// Reset values
// ****************************************
`define RTT_CNT_RST     16'h0000
`define RTT_PRE_RST     8'h00

`endif

// ### hdl/rtt_pkg.sv
package rtt_pkg;

  // Prescaler tap selection.
  typedef enum logic [1:0] {
    RTT_DIV4   = 2'h0,
    RTT_DIV16  = 2'h1,
    RTT_DIV64  = 2'h2,
    RTT_DIV256 = 2'h3
  } rtt_div_t;

  // Capture edge selection.
  typedef enum logic [1:0] {
    RTT_EDGE_NONE = 2'h0,
    RTT_EDGE_RISE = 2'h1,
    RTT_EDGE_FALL = 2'h2,
    RTT_EDGE_BOTH = 2'h3
  } rtt_edge_t;

  // Per-channel configuration bundle.
  typedef struct packed {
    logic      enable;     // Channel runs while high.
    logic      continuous; // One reloads at end, zero halts.
    logic      event_src;  // Count external events (channels 0 and 1 only).
    rtt_div_t  div_sel;    // Prescaler tap.
    rtt_edge_t cap_edge;   // Capture event selection.
    logic      pwm_en;     // Drive the pwm output.
    logic      cmp_en;     // Toggle the compare output on match.
    logic [15:0] reload;   // Start value.
    logic [15:0] compare;  // Compare and duty value.
  } rtt_cfg_t;

  // Per-channel status bundle.
  typedef struct packed {
    logic [15:0] count;    // Live counter value.
    logic [15:0] captured; // Last captured value.
    logic        running;  // Counter active.
  } rtt_stat_t;

endpackage : rtt_pkg

// ### hdl/rtt_channel.sv
`timescale 1ns/1ps
`include "rtt_defines.svh"

module rtt_channel
  import rtt_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  // Configuration and control
  input  wire rtt_cfg_t  cfg_i,
  input  wire logic      start_i,
  input  wire logic      evt_ok_i,
  input  wire logic      sync_load_i,
  // Pins
  input  wire logic      cap_pin_i,
  input  wire logic      evt_pin_i,
  // Results
  output rtt_stat_t      stat_o,
  output logic           tc_o,
  output logic           cap_o,
  output logic           cmp_o,
  output logic           pwm_raw_o
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0] cnt_reg,  cnt_next;   // Down counter.
  logic [15:0] capv_reg, capv_next;  // Captured value.
  logic [7:0]  pre_reg,  pre_next;   // Prescaler counter.
  logic        run_reg,  run_next;   // Running flag.
  logic        capd_reg, capd_next;  // Previous capture pin level.
  logic        evtd_reg, evtd_next;  // Previous event pin level.
  logic        cmp_reg,  cmp_next;   // Compare output level.
  logic        pwm_reg,  pwm_next;   // Pwm output level.
  logic        tc_reg,   tc_next;    // Terminal count pulse.
  logic        cap_reg,  cap_next;   // Capture pulse.
  logic [7:0]  tap;                  // Active prescaler mask.
  logic        tick;                 // Counting step.
  logic        cap_hit;              // Capture event this cycle.

  // Tap mask from the selection.
  always_comb begin
    unique case (cfg_i.div_sel)
      RTT_DIV4:   tap = `RTT_TAP_DIV4;
      RTT_DIV16:  tap = `RTT_TAP_DIV16;
      RTT_DIV64:  tap = `RTT_TAP_DIV64;
      RTT_DIV256: tap = `RTT_TAP_DIV256;
    endcase
  end

  // Next-state computation; event counting uses the pin's rising edge.
  always_comb begin
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    capv_next = capv_reg;
    cmp_next  = cmp_reg;
    tc_next   = 1'b0;
    cap_next  = 1'b0;
    capd_next = cap_pin_i;
    evtd_next = evt_pin_i;
    tick      = 1'b0;
    cap_hit   = (cfg_i.cap_edge[0] && cap_pin_i && !capd_reg) ||
                (cfg_i.cap_edge[1] && !cap_pin_i && capd_reg);
    if (cfg_i.event_src && evt_ok_i) begin
      tick = run_reg && evt_pin_i && !evtd_reg;
    end else if (run_reg) begin
      pre_next = (pre_reg & tap) == tap ? `RTT_PRE_RST : pre_reg + 8'h01;
      tick     = (pre_reg & tap) == tap;
    end
    if (start_i || sync_load_i) begin
      cnt_next = cfg_i.reload;
      pre_next = `RTT_PRE_RST;
      run_next = cfg_i.enable;
    end else if (!cfg_i.enable) begin
      run_next = 1'b0;
    end else if (tick) begin
      if (cnt_reg == 16'h0001 || cnt_reg == 16'h0000) begin
        tc_next = 1'b1;
        if (cfg_i.continuous) begin
          cnt_next = cfg_i.reload;
        end else begin
          cnt_next = 16'h0000;
          run_next = 1'b0;
        end
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
      if (cfg_i.cmp_en && cnt_next == cfg_i.compare) begin
        cmp_next = !cmp_reg;
      end
    end
    if (cap_hit) begin
      capv_next = cnt_reg;
      cap_next  = 1'b1;
    end
    pwm_next = cfg_i.pwm_en && run_reg && (cnt_reg <= cfg_i.compare);
  end

  // Register stage.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= `RTT_CNT_RST;
      capv_reg <= `RTT_CNT_RST;
      pre_reg  <= `RTT_PRE_RST;
      run_reg  <= 1'b0;
      capd_reg <= 1'b0;
      evtd_reg <= 1'b0;
      cmp_reg  <= 1'b0;
      pwm_reg  <= 1'b0;
      tc_reg   <= 1'b0;
      cap_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      capv_reg <= capv_next;
      pre_reg  <= pre_next;
      run_reg  <= run_next;
      capd_reg <= capd_next;
      evtd_reg <= evtd_next;
      cmp_reg  <= cmp_next;
      pwm_reg  <= pwm_next;
      tc_reg   <= tc_next;
      cap_reg  <= cap_next;
    end
  end

  assign stat_o    = '{count: cnt_reg, captured: capv_reg, running: run_reg};
  assign tc_o      = tc_reg;
  assign cap_o     = cap_reg;
  assign cmp_o     = cmp_reg;
  assign pwm_raw_o = pwm_reg;

  // ****************************************
  // Checks
  // ****************************************
  one_shot_halt_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tc_reg && !cfg_i.continuous && !$past(start_i) && !$past(sync_load_i) |-> !run_reg)
    else $error("One-shot timer kept running after terminal count.");
  reload_on_tc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tc_reg && $past(cfg_i.continuous) && $stable(cfg_i.reload) |-> cnt_reg == cfg_i.reload)
    else $error("Continuous timer did not reload.");
  count_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_reg && !tc_reg && !start_i && !sync_load_i && cfg_i.enable ##1 !tc_reg && !$past(start_i)
    |-> cnt_reg == $past(cnt_reg) || cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("Counter moved by more than one step.");
  capture_value_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cap_reg |-> capv_reg == $past(cnt_reg))
    else $error("Captured value differs from counter.");

endmodule : rtt_channel

// ### hdl/rtt_timer_array.sv
`timescale 1ns/1ps
`include "rtt_defines.svh"

module rtt_timer_array
  import rtt_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Channel configuration and control
  input  wire rtt_cfg_t [3:0]       cfg_i,
  input  wire logic [3:0]           start_i,
  input  wire logic                 pwm_sync_i,
  input  wire logic                 sync_start_i,
  // Power trip control
  input  wire logic                 trip_en_i,
  input  wire logic [1:0]           trip_sel_i,
  input  wire logic                 trip_clear_i,
  // Flag clearing
  input  wire logic [3:0]           tc_clear_i,
  input  wire logic [3:0]           cap_clear_i,
  // Pins
  input  wire logic [3:0]           cap_pin_i,
  input  wire logic [1:0]           evt_pin_i,
  output logic [3:0]                cmp_pin_o,
  output logic [3:0]                pwm_pin_o,
  // Status
  output rtt_stat_t [3:0]           stat_o,
  output logic [3:0]                tc_flag_o,
  output logic [3:0]                cap_flag_o,
  output logic                      tripped_o
);

  // ****************************************
  // Channel array
  // ****************************************
  logic [3:0] tc_pulse;   // Terminal count per channel.
  logic [3:0] cap_pulse;  // Capture per channel.
  logic [3:0] pwm_raw;    // Ungated pwm level.
  logic [3:0] tcf_reg,  tcf_next;   // Sticky terminal count flags.
  logic [3:0] capf_reg, capf_next;  // Sticky capture flags.
  logic       trip_reg, trip_next;  // Power trip latch.
  logic [3:0] pwm_reg,  pwm_next;   // Gated pwm outputs.

  // ****************************************
  // Theory of operation
  // ****************************************
  // Four identical channels sit side by side and share nothing but the clock,
  // the reset and the group load strobe. Each channel owns its prescaler, its
  // down counter, its capture latch, its compare toggle and its raw pwm level.
  // Keeping the channels apart means one channel can be started, stopped or
  // reprogrammed without disturbing the others.
  //
  // A start pulse loads the reload value into the counter and clears the
  // prescaler. The prescaler then counts up and offers one tick each time its
  // masked bits are all ones, so a tap of four gives one tick every fourth
  // cycle. The counter steps down once per tick.
  //
  // The terminal count is taken at the step from one, so the period equals the
  // reload value in ticks. A reload of zero also ends at once rather than
  // wrapping through the whole sixteen-bit range, which would surprise users.
  //
  // Channels 0 and 1 may count rising edges of their event pins instead of
  // prescaler ticks. Channels 2 and 3 have no event pin of their own, so the
  // event source bit is ignored there and they stay on the prescaler.
  //
  // The capture latch samples the live count on the selected pin edge. The
  // pin is taken as synchronous; a user with a truly asynchronous source must
  // add a synchroniser in front of this block, since none is inserted here.
  //
  // The sticky flags are set by one-cycle pulses from the channels and cleared
  // by one-cycle pulses from software. When both fall in the same cycle the
  // set wins, because losing an event costs more than a spurious flag.
  //
  // The power trip watches one capture pin chosen by the select input. The
  // trip latch holds until a clear arrives while the pin is low; a clear while
  // the pin is still active is overridden, so the outputs stay safe.
  //
  // The pwm gating uses the next trip value, so the pins drop at the very edge
  // at which the trip latches. This costs one gate level in the output path
  // but saves a whole cycle of uncontrolled drive after a fault.
  //
  // In group mode a single load strobe restarts every channel whose pwm drive
  // is enabled, so their periods begin on the same edge and stay aligned as
  // long as they share a tap and a reload value.
  //
  // Limitations: there is no interrupt logic here; the flags are plain outputs
  // for whoever gathers interrupts. There is no register map either; all
  // configuration arrives as levels on the configuration ports.
  //

  genvar g;
  generate
    for (g = 0; g < `RTT_NUM_CH; g++) begin : g_ch
      // In synchronised mode all pwm channels restart together.
      rtt_channel u_ch (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .cfg_i       (cfg_i[g]),
        .start_i     (start_i[g]),
        .evt_ok_i    (g < `RTT_NUM_EVT_CH),
        .sync_load_i (pwm_sync_i && sync_start_i && cfg_i[g].pwm_en),
        .cap_pin_i   (cap_pin_i[g]),
        .evt_pin_i   (evt_pin_i[g % `RTT_NUM_EVT_CH]),
        .stat_o      (stat_o[g]),
        .tc_o        (tc_pulse[g]),
        .cap_o       (cap_pulse[g]),
        .cmp_o       (cmp_pin_o[g]),
        .pwm_raw_o   (pwm_raw[g])
      );
    end
  endgenerate

  // ****************************************
  // Flags, trip and output gating
  // ****************************************
  // A set in the same cycle as a clear wins so no event is lost.
  always_comb begin
    tcf_next  = (tcf_reg & ~tc_clear_i) | tc_pulse;
    capf_next = (capf_reg & ~cap_clear_i) | cap_pulse;
    trip_next = trip_reg;
    if (trip_en_i && cap_pin_i[trip_sel_i]) begin
      trip_next = 1'b1;
    end else if (trip_clear_i) begin
      trip_next = 1'b0;
    end
    // The next trip value gates, so outputs drop on the same edge at which the trip latches.
    pwm_next = trip_next ? 4'h0 : pwm_raw;
  end

  // Register stage.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcf_reg  <= 4'h0;
      capf_reg <= 4'h0;
      trip_reg <= 1'b0;
      pwm_reg  <= 4'h0;
    end else begin
      tcf_reg  <= tcf_next;
      capf_reg <= capf_next;
      trip_reg <= trip_next;
      pwm_reg  <= pwm_next;
    end
  end

  // Flags and pins come straight from flip-flops, so they never glitch.
  assign tc_flag_o  = tcf_reg;   // Sticky terminal count flags.
  assign cap_flag_o = capf_reg;  // Sticky capture flags.
  assign tripped_o  = trip_reg;  // Trip latch state.
  assign pwm_pin_o  = pwm_reg;   // Gated pwm pins.

  // ****************************************
  // Checks
  // ****************************************
  trip_blocks_pwm_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trip_reg |-> pwm_pin_o == 4'h0)
    else $error("Pwm active while tripped.");
  trip_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trip_en_i && cap_pin_i[trip_sel_i] |=> trip_reg)
    else $error("Trip input did not latch.");
  tc_flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tc_pulse[0] |=> tc_flag_o[0])
    else $error("Terminal count flag not set.");
  trip_holds_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trip_reg && !trip_clear_i |=> trip_reg)
    else $error("Trip released without clear.");
  // A clear with the trip pin quiet must release the latch.
  trip_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trip_reg && trip_clear_i && !(trip_en_i && cap_pin_i[trip_sel_i]) |=> !trip_reg)
    else $error("Trip not released by clear.");
  // The group strobe must load pwm channels 0 and 1 on the same edge.
  sync_group_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pwm_sync_i && sync_start_i && cfg_i[0].pwm_en && cfg_i[1].pwm_en
    |=> stat_o[0].count == $past(cfg_i[0].reload) && stat_o[1].count == $past(cfg_i[1].reload))
    else $error("Group load missed a pwm channel.");
  // A capture pulse on channel 1 must leave its flag set.
  cap_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cap_pulse[1] |=> cap_flag_o[1])
    else $error("Capture flag not set.");

endmodule : rtt_timer_array

// ### tb/rtt_timer_array_tb.sv
`timescale 1ns/1ps
module rtt_timer_array_tb;
  import rtt_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic            ref_clk_i;
  logic            rst_n_i;
  rtt_cfg_t [3:0]  cfg;        // Per-channel setup held as levels.
  logic [3:0]      start;      // Start pulses.
  logic            trip_en;    // Trip detector on.
  logic            pwm_sync;   // Group mode level.
  logic            sync_start; // Group load pulse.
  logic [1:0]      trip_sel;   // Capture pin acting as trip.
  logic            trip_clr;   // Re-enable pulse for the pwm pins.
  logic [3:0]      tc_clr;     // Terminal flag clear pulses.
  logic [3:0]      cap_clr;    // Capture flag clear pulses.
  logic [3:0]      cap_pin;    // Capture pins.
  logic [1:0]      evt_pin;    // Event pins of channels 0 and 1.
  logic [3:0]      cmp_pin;    // Compare outputs.
  logic [3:0]      pwm_pin;    // Pwm outputs.
  rtt_stat_t [3:0] stat;       // Channel status.
  logic [3:0]      tc_flag;    // Terminal flags.
  logic [3:0]      cap_flag;   // Capture flags.
  logic            tripped;    // Trip latched.
  int              bad_count;  // Mismatches seen.
  int              check_count; // Comparisons made.
  int              cyc;        // Cycles waited.
  rtt_timer_array i_rtt_timer_array (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .start_i(start), .pwm_sync_i(pwm_sync),
    .sync_start_i(sync_start), .trip_en_i(trip_en), .trip_sel_i(trip_sel), .trip_clear_i(trip_clr),
    .tc_clear_i(tc_clr), .cap_clear_i(cap_clr), .cap_pin_i(cap_pin), .evt_pin_i(evt_pin),
    .cmp_pin_o(cmp_pin), .pwm_pin_o(pwm_pin), .stat_o(stat), .tc_flag_o(tc_flag),
    .cap_flag_o(cap_flag), .tripped_o(tripped));
  // ****************************************
  // Clock and watchdog
  // ****************************************
  // The clock runs at 10 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // The whole sequence needs about 900 cycles, so 20000 means a hang.
  initial begin
    #(100 * 20000);
    bad_count++;
    conclude();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  // Compares one value with its expectation.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits a bounded time for a tc (0), capture (1) or trip (2) flag.
  task automatic wait_hi(input int which, input int ch, output int n);
    logic f;
    n = 0;
    f = 1'b0;
    while (f !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
      f = (which == 0) ? tc_flag[ch] : (which == 1) ? cap_flag[ch] : tripped;
    end
    check({15'h0, f}, 16'h0001);
  endtask : wait_hi
  // Sets up one channel; the other fields stay off.
  task automatic setup(input int ch, input logic cont, input logic evt, input int dv,
                       input logic pwm, input logic [15:0] rel, input logic [15:0] cmpv);
    cfg[ch]            = '0;
    cfg[ch].enable     = 1'b1;
    cfg[ch].continuous = cont;
    cfg[ch].event_src  = evt;
    cfg[ch].div_sel    = rtt_div_t'(dv);
    cfg[ch].pwm_en     = pwm;
    cfg[ch].reload     = rel;
    cfg[ch].compare    = cmpv;
  endtask : setup
  // Pulses one bit of a control vector for one cycle: 0 start, 1 tc clear, 2 cap clear.
  task automatic pulse(input int which, input int ch);
    @(negedge ref_clk_i);
    if (which == 0) start[ch] = 1'b1;
    else if (which == 1) tc_clr[ch] = 1'b1;
    else cap_clr[ch] = 1'b1;
    @(negedge ref_clk_i);
    start = '0;
    tc_clr = '0;
    cap_clr = '0;
  endtask : pulse
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    bad_count = 0; check_count = 0; cfg = '0; start = '0; trip_en = 1'b0; trip_sel = 2'h0;
    trip_clr = 1'b0; tc_clr = '0; cap_clr = '0; cap_pin = '0; evt_pin = '0; rst_n_i = 1'b0;
    pwm_sync = 1'b0; sync_start = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    check(stat[0].count, 16'h0000);
    check({12'h0, tc_flag}, 16'h0000);
    check({12'h0, pwm_pin}, 16'h0000);
    $display("Test reset done");
    // Each channel gets its own tap; reload 2 must end after about two taps.
    for (int d = 0; d < 4; d++) begin
      setup(d, 1'b0, 1'b0, d, 1'b0, 16'h0002, 16'h0000);
      pulse(0, d);
      check(stat[d].count, 16'h0002);
      wait_hi(0, d, cyc);
      check({15'h0, (cyc >= (8 << (2 * d)) - 4 && cyc <= (8 << (2 * d)) + 2)}, 16'h0001);
      repeat (3) @(negedge ref_clk_i);
      check(stat[d].count, 16'h0000);
      check({15'h0, stat[d].running}, 16'h0000);
      pulse(1, d);
      check({15'h0, tc_flag[d]}, 16'h0000);
    end
    $display("Test one-shot taps done");
    // Continuous mode must keep running and set the flag again after a clear.
    setup(0, 1'b1, 1'b0, 0, 1'b0, 16'h0003, 16'h0000);
    pulse(0, 0);
    wait_hi(0, 0, cyc);
    pulse(1, 0);
    wait_hi(0, 0, cyc);
    check({15'h0, (cyc >= 8 && cyc <= 14)}, 16'h0001);
    check({15'h0, stat[0].running}, 16'h0001);
    check({15'h0, (stat[0].count <= 16'h0003 && stat[0].count != 16'h0000)}, 16'h0001);
    cfg[0] = '0;
    pulse(1, 0);
    $display("Test continuous done");
    // Event counting: each rising edge on the event pin is one step.
    setup(0, 1'b0, 1'b1, 3, 1'b0, 16'h0003, 16'h0000);
    pulse(0, 0);
    repeat (20) @(negedge ref_clk_i);
    check(stat[0].count, 16'h0003);
    for (int k = 0; k < 3; k++) begin
      evt_pin[0] = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      evt_pin[0] = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      if (k == 0) check(stat[0].count, 16'h0002);
    end
    wait_hi(0, 0, cyc);
    check({15'h0, (cyc <= 3)}, 16'h0001);
    $display("Test events done");
    // Capture latches the live count at the pin's rising edge.
    setup(1, 1'b1, 1'b0, 0, 1'b0, 16'h0100, 16'h0000);
    cfg[1].cap_edge = RTT_EDGE_RISE;
    pulse(0, 1);
    repeat (20) @(negedge ref_clk_i);
    cap_pin[1] = 1'b1;
    wait_hi(1, 1, cyc);
    check({15'h0, (stat[1].captured >= 16'h00F8 && stat[1].captured <= 16'h00FE)}, 16'h0001);
    pulse(2, 1);
    check({15'h0, cap_flag[1]}, 16'h0000);
    $display("Test capture done");
    // A trip on the chosen capture pin drops the pwm pin until re-enabled.
    setup(3, 1'b1, 1'b0, 0, 1'b1, 16'h0100, 16'hFFFF);
    pulse(0, 3);
    repeat (3) @(negedge ref_clk_i);
    check({15'h0, pwm_pin[3]}, 16'h0001);
    trip_en = 1'b1;
    trip_sel = 2'h2;
    cap_pin[2] = 1'b1;
    wait_hi(2, 0, cyc);
    check({15'h0, pwm_pin[3]}, 16'h0000);
    cap_pin[2] = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check({15'h0, tripped}, 16'h0001);
    trip_clr = 1'b1;
    @(negedge ref_clk_i);
    trip_clr = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check({15'h0, tripped}, 16'h0000);
    check({15'h0, pwm_pin[3]}, 16'h0001);
    $display("Test trip done");
    // Compare toggles its pin each time the count steps onto the compare value.
    setup(2, 1'b1, 1'b0, 0, 1'b0, 16'h0004, 16'h0002);
    cfg[2].cmp_en = 1'b1;
    pulse(0, 2);
    repeat (5) @(negedge ref_clk_i);
    check({15'h0, cmp_pin[2]}, 16'h0000);
    repeat (4) @(negedge ref_clk_i);
    check({15'h0, cmp_pin[2]}, 16'h0001);
    repeat (15) @(negedge ref_clk_i);
    check({15'h0, cmp_pin[2]}, 16'h0000);
    cfg[2] = '0;
    // Group mode: one strobe loads every pwm channel together.
    setup(0, 1'b1, 1'b0, 0, 1'b1, 16'h0010, 16'h0008);
    setup(1, 1'b1, 1'b0, 0, 1'b1, 16'h0020, 16'h0008);
    pwm_sync = 1'b1;
    repeat (40) @(negedge ref_clk_i);
    sync_start = 1'b1;
    @(negedge ref_clk_i);
    sync_start = 1'b0;
    check(stat[0].count, 16'h0010);
    check(stat[1].count, 16'h0020);
    check(stat[3].count, 16'h0100);
    check({15'h0, stat[2].running}, 16'h0000);
    $display("Test group done");
    conclude();
  end
endmodule : rtt_timer_array_tb
